// ==== sbs_pkg.sv ====
// Package: instruction codes, widths and reset values of the scan port
package sbs_pkg;
  // ==========================================
  // Instruction codes
  localparam int IR_W = 3;
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] IR_PRIV3 = 3'h3;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_PRIV5 = 3'h5;
  localparam logic [2:0] IR_PRIV6 = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  // ==========================================
  // Widths and counts
  localparam int ID_W = 32;
  localparam int BSR_W_DEF = 16;
  localparam int RESET_ONES = 5;
  // Arbitrary neutral identity value
  localparam logic [31:0] ID_VALUE_DEF = 32'h0000_0001;
endpackage

// ==== sbs_sync.sv ====
// Module: two-flop synchroniser for one pin
`timescale 1ns/1ps
module sbs_sync #(
  // Reset level; should match the idle level of the pin
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Level
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s1_nxt;
  logic q_nxt;
  always_comb begin
    s1_nxt = d;
    q_nxt = s1_r;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_r <= s1_nxt;
      q <= q_nxt;
    end
  end
endmodule

// ==== sbs_tap_fsm.sv ====
// Module: sixteen-state test port controller advanced on test clock rises
`timescale 1ns/1ps
module sbs_tap_fsm (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Advance
  input wire logic tck_rise,
  input wire logic mode_sel,
  // State
  output logic [15:0] state
);
  // ==========================================
  // One-hot states
  typedef enum logic [15:0] {
    S_TLR = 16'h0001, S_RTI = 16'h0002, S_SELDR = 16'h0004, S_CAPDR = 16'h0008,
    S_SHDR = 16'h0010, S_EX1DR = 16'h0020, S_PADR = 16'h0040, S_EX2DR = 16'h0080,
    S_UPDR = 16'h0100, S_SELIR = 16'h0200, S_CAPIR = 16'h0400, S_SHIR = 16'h0800,
    S_EX1IR = 16'h1000, S_PAIR = 16'h2000, S_EX2IR = 16'h4000, S_UPIR = 16'h8000
  } sbs_state_e;
  sbs_state_e st_r;
  sbs_state_e st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (tck_rise) begin
      unique case (st_r)
        S_TLR: st_nxt = mode_sel ? S_TLR : S_RTI;
        S_RTI: st_nxt = mode_sel ? S_SELDR : S_RTI;
        S_SELDR: st_nxt = mode_sel ? S_SELIR : S_CAPDR;
        S_CAPDR: st_nxt = mode_sel ? S_EX1DR : S_SHDR;
        S_SHDR: st_nxt = mode_sel ? S_EX1DR : S_SHDR;
        S_EX1DR: st_nxt = mode_sel ? S_UPDR : S_PADR;
        S_PADR: st_nxt = mode_sel ? S_EX2DR : S_PADR;
        S_EX2DR: st_nxt = mode_sel ? S_UPDR : S_SHDR;
        S_UPDR: st_nxt = mode_sel ? S_SELDR : S_RTI;
        S_SELIR: st_nxt = mode_sel ? S_TLR : S_CAPIR;
        S_CAPIR: st_nxt = mode_sel ? S_EX1IR : S_SHIR;
        S_SHIR: st_nxt = mode_sel ? S_EX1IR : S_SHIR;
        S_EX1IR: st_nxt = mode_sel ? S_UPIR : S_PAIR;
        S_PAIR: st_nxt = mode_sel ? S_EX2IR : S_PAIR;
        S_EX2IR: st_nxt = mode_sel ? S_UPIR : S_SHIR;
        S_UPIR: st_nxt = mode_sel ? S_SELDR : S_RTI;
        default: st_nxt = S_TLR;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_TLR;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign state = st_r;
endmodule

// ==== sbs_scan_port.sv ====
// Module: instruction layer of the memory boundary-scan test port
// ==========================================
// How it works
// - Bypass code puts one-bit bypass in path
// - Sample code captures all pin levels
// - Unpinned cells capture fixed default value
// - Shift-DR shifts the boundary register
// - Update-DR loads output cell holding registers
// - All-zero code decodes as external test
// - External test leaves memory inputs on core
// - External test drives holds at Update-IR fall
// - External test captures pins on Capture-DR
// - External test Update-DR drives output pins
// - Identity code captures and shifts 32-bit ID
// - Reset and Test-Logic-Reset load identity code
// - Float code samples and floats memory outputs
// - Three remaining codes are private, act bypass
// - Three-bit instruction acts at Update-IR
// - Capture-IR loads 01 into low bits
// - Five mode-high rises reach Test-Logic-Reset
// - Identity shifts least significant bit first
`timescale 1ns/1ps
module sbs_scan_port #(
  parameter int BSR_W = sbs_pkg::BSR_W_DEF,
  parameter int OUT_W = 8,
  parameter logic [BSR_W-1:0] PIN_MASK = '1,
  parameter logic [BSR_W-1:0] CELL_DEFAULT = '1,
  parameter logic [31:0] ID_VALUE = sbs_pkg::ID_VALUE_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Test pins
  input wire logic tck,
  input wire logic mode_sel,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Pin ring
  input wire logic [BSR_W-1:0] ring_in,
  input wire logic [OUT_W-1:0] core_out,
  input wire logic core_out_en,
  output logic [OUT_W-1:0] pin_out,
  output logic pin_out_en,
  output logic core_in_pass
);
  // ==========================================
  // Elaboration check
  if (BSR_W < OUT_W || OUT_W < 1) begin : g_bad
    $error("Boundary register narrower than output ring");
  end

  // ==========================================
  // Synchronisers and test clock edges
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_d_r;
  logic tck_d_nxt;
  logic tck_rise;
  logic tck_fall;
  // Test clock idles low, so its stages reset low: no false edge after reset
  sbs_sync #(.RST_VAL(1'b0)) u_ck (.sys_clk(sys_clk), .nrst(nrst), .d(tck),
    .q(tck_s));
  sbs_sync u_ms (.sys_clk(sys_clk), .nrst(nrst), .d(mode_sel), .q(tms_s));
  sbs_sync u_di (.sys_clk(sys_clk), .nrst(nrst), .d(tdi), .q(tdi_s));
  assign tck_d_nxt = tck_s;
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  logic [15:0] st;
  sbs_tap_fsm u_fsm (.sys_clk(sys_clk), .nrst(nrst), .tck_rise(tck_rise),
    .mode_sel(tms_s), .state(st));
  logic s_tlr, s_capdr, s_shdr, s_updr, s_capir, s_shir, s_upir;
  assign s_tlr = st[0];
  assign s_capdr = st[3];
  assign s_shdr = st[4];
  assign s_updr = st[8];
  assign s_capir = st[10];
  assign s_shir = st[11];
  assign s_upir = st[15];

  // ==========================================
  // Run of mode-high rises, kept only for the reset check
  logic [2:0] ones_r;
  logic [2:0] ones_nxt;
  always_comb begin
    ones_nxt = ones_r;
    if (tck_rise) begin
      if (!tms_s) begin
        ones_nxt = 3'h0;
      end else if (ones_r != 3'(sbs_pkg::RESET_ONES)) begin
        ones_nxt = ones_r + 3'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ones_r <= 3'h0;
    end else begin
      ones_r <= ones_nxt;
    end
  end

  // ==========================================
  // Decode
  function automatic logic uses_bsr(input logic [2:0] c);
    return c == sbs_pkg::IR_EXTEST || c == sbs_pkg::IR_SAMPLE ||
      c == sbs_pkg::IR_SAMPLE_Z;
  endfunction

  // ==========================================
  // Registers
  logic [2:0] ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic byp_r, byp_nxt;
  logic [31:0] id_r, id_nxt;
  logic [BSR_W-1:0] bsr_r, bsr_nxt;
  logic [OUT_W-1:0] hold_r, hold_nxt;
  logic tdo_r, tdo_nxt, oe_r, oe_nxt;
  logic drive_r, drive_nxt;
  logic float_r, float_nxt;
  logic serial_bit;

  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    id_nxt = id_r;
    bsr_nxt = bsr_r;
    hold_nxt = hold_r;
    drive_nxt = drive_r;
    float_nxt = float_r;
    // Applied while the controller sits in reset, so a stopped clock cannot keep a drive
    if (s_tlr) begin
      ir_nxt = sbs_pkg::IR_IDCODE;
      drive_nxt = 1'b0;
      float_nxt = 1'b0;
    end
    if (tck_rise) begin
      if (s_capir) begin
        ir_sh_nxt = {ir_sh_r[2], sbs_pkg::IR_CAPTURE_LOW};
      end
      if (s_shir) begin
        ir_sh_nxt = {tdi_s, ir_sh_r[2:1]};
      end
      if (s_capdr) begin
        byp_nxt = 1'b0;
        if (ir_r == sbs_pkg::IR_IDCODE) begin
          id_nxt = ID_VALUE;
        end
        if (uses_bsr(ir_r)) begin
          bsr_nxt = (ring_in & PIN_MASK) | (CELL_DEFAULT & ~PIN_MASK);
        end
      end
      if (s_shdr) begin
        unique case (ir_r)
          sbs_pkg::IR_IDCODE: id_nxt = {tdi_s, id_r[31:1]};
          sbs_pkg::IR_EXTEST, sbs_pkg::IR_SAMPLE, sbs_pkg::IR_SAMPLE_Z:
            bsr_nxt = {tdi_s, bsr_r[BSR_W-1:1]};
          default: byp_nxt = tdi_s;
        endcase
      end
    end
    if (tck_fall) begin
      if (s_updr && uses_bsr(ir_r)) begin
        hold_nxt = bsr_r[OUT_W-1:0];
      end
      if (s_upir) begin
        ir_nxt = ir_sh_r;
        drive_nxt = ir_sh_r == sbs_pkg::IR_EXTEST;
        float_nxt = ir_sh_r == sbs_pkg::IR_SAMPLE_Z;
      end
    end
  end

  // Serial out picks the selected register, updated on test clock falls
  always_comb begin
    serial_bit = byp_r;
    if (s_shir) begin
      serial_bit = ir_sh_r[0];
    end else if (ir_r == sbs_pkg::IR_IDCODE) begin
      serial_bit = id_r[0];
    end else if (uses_bsr(ir_r)) begin
      serial_bit = bsr_r[0];
    end
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (tck_fall) begin
      oe_nxt = s_shdr | s_shir;
      tdo_nxt = serial_bit;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tck_d_r <= 1'b0;
      ir_sh_r <= sbs_pkg::IR_IDCODE;
      ir_r <= sbs_pkg::IR_IDCODE;
      byp_r <= 1'b0;
      id_r <= '0;
      bsr_r <= '0;
      hold_r <= '0;
      drive_r <= 1'b0;
      float_r <= 1'b0;
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      tck_d_r <= tck_d_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      id_r <= id_nxt;
      bsr_r <= bsr_nxt;
      hold_r <= hold_nxt;
      drive_r <= drive_nxt;
      float_r <= float_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ==========================================
  // Outputs; core inputs never blocked, even under external test
  assign tdo = tdo_r;
  assign tdo_oe = oe_r;
  assign pin_out = drive_r ? hold_r : core_out;
  assign pin_out_en = float_r ? 1'b0 : (drive_r | core_out_en);
  assign core_in_pass = 1'b1;

  // ==========================================
  // Assertions
  reset_ir_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_tlr && tck_rise |=> ir_r == sbs_pkg::IR_IDCODE)
    else $error("Instruction not reset to identity");
  capir_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_capir && tck_rise |=> ir_sh_r[1:0] == sbs_pkg::IR_CAPTURE_LOW)
    else $error("Capture-IR pattern wrong");
  ir_update_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(s_upir && tck_fall) |=> ir_r == $past(ir_r) || $past(s_tlr))
    else $error("Instruction changed outside update");
  id_cap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_capdr && tck_rise && ir_r == sbs_pkg::IR_IDCODE |=> id_r == ID_VALUE)
    else $error("Identity not captured");
  id_shift_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shdr && tck_rise && ir_r == sbs_pkg::IR_IDCODE |=> id_r[30:0] == $past(id_r[31:1]))
    else $error("Identity shift order wrong");
  bsr_cap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_capdr && tck_rise && uses_bsr(ir_r) |=>
      bsr_r == (($past(ring_in) & PIN_MASK) | (CELL_DEFAULT & ~PIN_MASK)))
    else $error("Boundary capture wrong");
  bypass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shdr && tck_rise && ir_r == sbs_pkg::IR_BYPASS |=> byp_r == $past(tdi_s))
    else $error("Bypass bit not shifted");
  float_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ir_r == sbs_pkg::IR_SAMPLE_Z && !$past(s_tlr) |-> !pin_out_en)
    else $error("Outputs not floated");
  extest_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    drive_r |-> pin_out == hold_r && pin_out_en)
    else $error("External test not driving hold");
  tdo_oe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(tdo_oe) |-> $past(tck_fall) && $past(s_shdr | s_shir))
    else $error("Serial out enabled outside shift");
  tdo_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(tck_fall) |-> $stable(tdo) && $stable(tdo_oe))
    else $error("Serial out moved without a test clock fall");
  tdo_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    tck_fall && !s_shdr && !s_shir |=> !tdo_oe)
    else $error("Serial out left enabled outside shift");
  bsr_shift_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shdr && tck_rise && uses_bsr(ir_r) |=>
      bsr_r == {$past(tdi_s), $past(bsr_r[BSR_W-1:1])})
    else $error("Boundary shift wrong");
  hold_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_updr && tck_fall && uses_bsr(ir_r) |=> hold_r == $past(bsr_r[OUT_W-1:0]))
    else $error("Output holds not updated");
  hold_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(s_updr && tck_fall) |=> hold_r == $past(hold_r))
    else $error("Output holds changed outside update");
  ir_shift_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_shir && tck_rise |=> ir_sh_r == {$past(tdi_s), $past(ir_sh_r[2:1])})
    else $error("Instruction shift wrong");
  extest_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    drive_r == (ir_r == sbs_pkg::IR_EXTEST))
    else $error("External test drive does not match instruction");
  float_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    float_r == (ir_r == sbs_pkg::IR_SAMPLE_Z))
    else $error("Float does not match instruction");
  byp_cap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_capdr && tck_rise |=> !byp_r)
    else $error("Bypass bit not cleared on capture");
  five_ones_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ones_r == 3'(sbs_pkg::RESET_ONES) |-> s_tlr)
    else $error("Five mode-high rises did not reach reset");

  // ==========================================
  // Cover points
  cap_id_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    s_capdr && tck_rise && ir_r == sbs_pkg::IR_IDCODE);
  ext_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(drive_r));
  float_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(float_r));
  byp_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    s_shdr && tck_rise && ir_r == sbs_pkg::IR_BYPASS);
  tlr_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    ones_r == 3'(sbs_pkg::RESET_ONES) && tck_rise);
endmodule

// ==== sbs_tester.sv ====
// Partner model: board tester that drives the test pins
`timescale 1ns/1ps
module sbs_tester (
  // Clock
  input wire logic sys_clk,
  // Test pins
  output logic tck,
  output logic mode_sel,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ==========================================
  // Test clock stands low between steps
  initial begin
    tck = 1'b0;
    mode_sel = 1'b1;
    tdi = 1'b1;
  end
  // One 400 ns period; tdo read late in high phase, clear of the fall
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    mode_sel <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (4) @(posedge sys_clk);
    o = tdo;
    oe = tdo_oe;
    tck <= 1'b0;
  endtask
  // No reset pin, so five mode-high rises stand in for it
  task automatic to_reset();
    logic o;
    logic oe;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b1, o, oe);
  endtask
endmodule

// ==== sbs_scan_port_tb.sv ====
// Testbench: scan port driven through the board tester model
`timescale 1ns/1ps
module sbs_scan_port_tb;
  localparam int BW = 16;
  localparam int OW = 8;
  localparam logic [BW-1:0] MASK = 16'hf0ff;
  localparam logic [BW-1:0] DEFV = 16'h0a00;
  // Arbitrary identity value
  localparam logic [31:0] IDV = 32'h5a3c_96e1;
  logic sys_clk, nrst, tck, mode_sel, tdi, tdo, tdo_oe;
  logic core_out_en, pin_out_en, core_in_pass;
  logic [BW-1:0] ring_in;
  logic [OW-1:0] core_out, pin_out;
  logic [31:0] q;
  int failures = 0;
  int checked = 0;
  sbs_scan_port #(.BSR_W(BW), .OUT_W(OW), .PIN_MASK(MASK), .CELL_DEFAULT(DEFV),
    .ID_VALUE(IDV)) dut (.sys_clk(sys_clk), .nrst(nrst), .tck(tck), .mode_sel(mode_sel),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .core_out(core_out),
    .core_out_en(core_out_en), .pin_out(pin_out), .pin_out_en(pin_out_en),
    .core_in_pass(core_in_pass));
  sbs_tester tester (.sys_clk(sys_clk), .tck(tck), .mode_sel(mode_sel), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe));
  // ==========================================
  // Clock and shared tasks
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Idle to idle through one scan; n bits, bit 0 first
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    logic oe;
    dout = '0;
    tester.step(1'b1, 1'b1, o, oe);
    if (ir) tester.step(1'b1, 1'b1, o, oe);
    tester.step(1'b0, 1'b1, o, oe);
    tester.step(1'b0, 1'b1, o, oe);
    for (int i = 0; i < n; i++) begin
      tester.step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      chk("tdo_oe shifting", 32'h1, {31'h0, oe});
    end
    tester.step(1'b1, 1'b1, o, oe);
    tester.step(1'b0, 1'b1, o, oe);
    chk("tdo_oe idle", 32'h0, {31'h0, tdo_oe});
  endtask
  task automatic ir_load(input logic [2:0] c);
    scan(1'b1, 3, {29'h0, c}, q);
    chk("capture ir", 32'h1, q & 32'h3);
  endtask
  function automatic logic [31:0] cap(input logic [BW-1:0] r);
    return {16'h0, (r & MASK) | (DEFV & ~MASK)};
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("tdo_oe reset", 32'h0, {31'h0, tdo_oe});
    chk("pin_out reset", {24'h0, core_out}, {24'h0, pin_out});
    chk("core_in_pass", 32'h1, {31'h0, core_in_pass});
  endtask
  task automatic t_idcode();
    scan(1'b0, 32, 32'hffff_ffff, q);
    chk("id shift", IDV, q);
  endtask
  task automatic t_bypass();
    logic [2:0] codes [4];
    codes = '{sbs_pkg::IR_BYPASS, sbs_pkg::IR_PRIV3, sbs_pkg::IR_PRIV5, sbs_pkg::IR_PRIV6};
    foreach (codes[k]) begin
      ir_load(codes[k]);
      scan(1'b0, 4, 32'h6, q);
      chk("bypass delay", 32'h6, (q >> 1) & 32'h7);
    end
  endtask
  task automatic t_sample();
    // Ring held steady across capture; memory clock left running
    ring_in <= 16'ha5c3;
    ir_load(sbs_pkg::IR_SAMPLE);
    scan(1'b0, BW, 32'h00e7, q);
    chk("sample capture", cap(16'ha5c3), q);
    chk("sample pin_out", {24'h0, core_out}, {24'h0, pin_out});
  endtask
  task automatic t_extest();
    // Core enable off, so only the test drive can raise the driver enable
    core_out_en <= 1'b0;
    ir_load(sbs_pkg::IR_EXTEST);
    chk("preload drive", 32'he7, {24'h0, pin_out});
    chk("extest enable", 32'h1, {31'h0, pin_out_en});
    chk("extest core", 32'h1, {31'h0, core_in_pass});
    ring_in <= 16'h1234;
    scan(1'b0, BW, 32'h0081, q);
    chk("extest capture", cap(16'h1234), q);
    chk("extest update", 32'h81, {24'h0, pin_out});
    core_out_en <= 1'b1;
  endtask
  task automatic t_float_reset();
    logic o;
    logic oe;
    ir_load(sbs_pkg::IR_SAMPLE_Z);
    chk("float enable", 32'h0, {31'h0, pin_out_en});
    tester.to_reset();
    tester.step(1'b0, 1'b1, o, oe);
    chk("reset enable", {31'h0, core_out_en}, {31'h0, pin_out_en});
    chk("reset pin_out", {24'h0, core_out}, {24'h0, pin_out});
    t_idcode();
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    nrst = 1'b0;
    ring_in = 16'h0;
    core_out = 8'h3c;
    core_out_en = 1'b1;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    tester.step(1'b0, 1'b1, q[0], q[1]);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_float_reset();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    final_report();
  end
endmodule
